// ==== core/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC = 11;
    localparam int SRC_W = 4;
    localparam int NUM_LEVEL = 4;
    localparam int LEVEL_W = 2;
    localparam int REG_W = 8;
    localparam int BANK0_W = 7;
    localparam int BANK1_W = 4;
    localparam int VEC_W = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int SYNC_W = 2;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_ENABLE0 = 8'ha8;
    localparam logic [7:0] IDX_PRIO_LOW0 = 8'hb8;
    localparam logic [7:0] IDX_PRIO_HIGH0 = 8'hb7;
    localparam logic [7:0] IDX_ENABLE1 = 8'ha9;
    localparam logic [7:0] IDX_PRIO_LOW1 = 8'hb9;
    localparam logic [7:0] IDX_PRIO_HIGH1 = 8'hb6;
    localparam logic [7:0] IDX_STATUS = 8'hc0;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam int GLOBAL_EN_BIT = 7;

    // status word fields
    localparam int ST_INSERV_LSB = 0;
    localparam int ST_SRC_LSB = 4;
    localparam int ST_REQ_BIT = 8;
    localparam int ST_LEVEL_LSB = 9;
    localparam int ST_PEND_LSB = 16;

    // ------------------------------------------------------------
    // sources, index order is also the polling order
    // ------------------------------------------------------------
    localparam logic [SRC_W-1:0] SRC_EXT0 = 4'h0;
    localparam logic [SRC_W-1:0] SRC_TIMER0 = 4'h1;
    localparam logic [SRC_W-1:0] SRC_EXT1 = 4'h2;
    localparam logic [SRC_W-1:0] SRC_TIMER1 = 4'h3;
    localparam logic [SRC_W-1:0] SRC_SERIAL = 4'h4;
    localparam logic [SRC_W-1:0] SRC_TIMER2 = 4'h5;
    localparam logic [SRC_W-1:0] SRC_COUNTER = 4'h6;
    localparam logic [SRC_W-1:0] SRC_KEYPAD = 4'h7;
    localparam logic [SRC_W-1:0] SRC_SPI = 4'h8;
    localparam logic [SRC_W-1:0] SRC_USB = 4'h9;
    localparam logic [SRC_W-1:0] SRC_AUX = 4'ha;

    // vector addresses
    localparam logic [VEC_W-1:0] VEC_EXT0 = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_TIMER0 = 16'h000b;
    localparam logic [VEC_W-1:0] VEC_EXT1 = 16'h0013;
    localparam logic [VEC_W-1:0] VEC_TIMER1 = 16'h001b;
    localparam logic [VEC_W-1:0] VEC_SERIAL = 16'h0023;
    localparam logic [VEC_W-1:0] VEC_TIMER2 = 16'h002b;
    localparam logic [VEC_W-1:0] VEC_COUNTER = 16'h0033;
    localparam logic [VEC_W-1:0] VEC_KEYPAD = 16'h003b;
    localparam logic [VEC_W-1:0] VEC_AUX = 16'h0043;
    localparam logic [VEC_W-1:0] VEC_SPI = 16'h004b;
    localparam logic [VEC_W-1:0] VEC_USB = 16'h006b;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== core/irq_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none

module irq_arbiter (
    // requests already masked by the enables
    input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] pending,
    input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] prioLow,
    input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] prioHigh,
    // winner
    output logic winValid,
    output logic [irq_ctrl_pkg::SRC_W-1:0] winSrc,
    output logic [irq_ctrl_pkg::LEVEL_W-1:0] winLevel
);

    // ------------------------------------------------------------
    // per-source level
    // ------------------------------------------------------------
    logic [irq_ctrl_pkg::LEVEL_W-1:0] srcLevel [irq_ctrl_pkg::NUM_SRC];

    genvar g;
    generate
        for (g = 0; g < irq_ctrl_pkg::NUM_SRC; g++) begin : gLevel
            // high bit is the most significant one [RULE5]
            assign srcLevel[g] = {prioHigh[g], prioLow[g]}; // [RULE4]
        end
    endgenerate

    // ------------------------------------------------------------
    // pick highest level, lowest index within a level
    // ------------------------------------------------------------
    // walking downward with >= lets the lower index win a tie
    always_comb begin
        winValid = 1'b0;
        winSrc = '0;
        winLevel = '0;
        for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i] && (!winValid || srcLevel[i] >= winLevel)) begin // [RULE9] [RULE10]
                winValid = 1'b1;
                winSrc = irq_ctrl_pkg::SRC_W'(i);
                winLevel = srcLevel[i];
            end
        end
    end

endmodule

`default_nettype wire

// ==== core/irq_controller.sv ====
// How it works
// [RULE1] eleven request sources: two pins, three timers, serial, spi, keypad, usb, counter, aux.
// [RULE2] each source has its own enable; a disabled source is never forwarded.
// [RULE3] a cleared global enable blocks every source at once.
// [RULE4] each source gets one low and one high priority bit, four levels.
// [RULE5] level is high bit then low bit: 00 lowest up to 11 highest.
// [RULE6] counter vector 0033h, spi vector 004bh, keypad vector 003bh.
// [RULE7] a running service is preempted only by a strictly higher level.
// [RULE8] service at the top level is never preempted.
// [RULE9] of simultaneous requests the higher level is granted.
// [RULE10] equal levels are resolved by a fixed polling order, lowest index first.
// [RULE11] global enable is bit 7 of the enable register at a8h.
// [RULE12] low priority bits at b8h, high priority bits at b7h, bit per source.
// [RULE13] a return restores the previous in-service level and re-arbitrates.
// [RULE14] the core pulses accept on taking a grant and return on exit.
`timescale 1ns/1ps
`default_nettype none

module irq_controller (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // request sources
    input wire logic [irq_ctrl_pkg::SYNC_W-1:0] extRequestPin,
    input wire logic [irq_ctrl_pkg::NUM_SRC-irq_ctrl_pkg::SYNC_W-1:0] periphReq,
    // processor core side
    output logic irqReq,
    output logic [irq_ctrl_pkg::VEC_W-1:0] irqVector,
    output logic [irq_ctrl_pkg::LEVEL_W-1:0] irqLevel,
    input wire logic irqAck,
    input wire logic irqReturn,
    output logic idleWake,
    // axi4-lite write
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [irq_ctrl_pkg::DATA_W-1:0] wdata,
    input wire logic [irq_ctrl_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [irq_ctrl_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    localparam int NS = irq_ctrl_pkg::NUM_SRC;
    localparam int B0 = irq_ctrl_pkg::BANK0_W;
    localparam int B1 = irq_ctrl_pkg::BANK1_W;
    localparam int SW = irq_ctrl_pkg::SYNC_W;

    // ------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------
    function automatic logic [8:0] decode(input logic [irq_ctrl_pkg::ADDR_W-1:0] a);
        logic ok;
        ok = (a[1:0] == 2'h0) && (a[irq_ctrl_pkg::ADDR_W-1:10] == 2'h0);
        return {ok, a[9:2]};
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0] sync1_q, sync1_d, sync2_q, sync2_d, sync3_q, sync3_d;
    logic [SW-1:0] extLevel_q, extLevel_d;

    // a change counts only once the second and third stage agree
    always_comb begin
        sync1_d = extRequestPin;
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        extLevel_d = ((sync2_q ~^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & extLevel_q);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            extLevel_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            extLevel_q <= extLevel_d;
        end
    end

    // ------------------------------------------------------------
    // configuration registers and axi write channel
    // ------------------------------------------------------------
    logic [NS-1:0] srcEnable_q, srcEnable_d, prioLow_q, prioLow_d, prioHigh_q, prioHigh_d;
    logic globalEn_q, globalEn_d;
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
    logic [irq_ctrl_pkg::ADDR_W-1:0] awAddr_q, awAddr_d, wrAddr;
    logic [irq_ctrl_pkg::REG_W-1:0] wData_q, wData_d, wrData;
    logic wStrb_q, wStrb_d, wrStrb, awHave, wHave, doWrite;
    logic [1:0] bresp_q, bresp_d;
    logic [8:0] wrDec;

    assign awready = !awHeld_q && !bvalid_q;
    assign wready = !wHeld_q && !bvalid_q;
    assign awHave = awHeld_q || (awvalid && awready);
    assign wHave = wHeld_q || (wvalid && wready);
    // both halves present, in either order
    assign doWrite = awHave && wHave && !bvalid_q;
    assign wrAddr = awHeld_q ? awAddr_q : awaddr;
    assign wrData = wHeld_q ? wData_q : wdata[irq_ctrl_pkg::REG_W-1:0];
    assign wrStrb = wHeld_q ? wStrb_q : wstrb[0];
    assign wrDec = decode(wrAddr);

    // only the low byte lane holds register bits
    always_comb begin
        srcEnable_d = srcEnable_q;
        globalEn_d = globalEn_q;
        prioLow_d = prioLow_q;
        prioHigh_d = prioHigh_q;
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q && !bready;
        bresp_d = bresp_q;
        if (awvalid && awready) begin
            awHeld_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready) begin
            wHeld_d = 1'b1;
            wData_d = wdata[irq_ctrl_pkg::REG_W-1:0];
            wStrb_d = wstrb[0];
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = irq_ctrl_pkg::RESP_OKAY;
            if (!wrDec[8]) begin
                bresp_d = irq_ctrl_pkg::RESP_SLVERR;
            end else begin
                case (wrDec[7:0])
                    irq_ctrl_pkg::IDX_ENABLE0: begin
                        if (wrStrb) begin
                            globalEn_d = wrData[irq_ctrl_pkg::GLOBAL_EN_BIT]; // [RULE11] [RULE3]
                            srcEnable_d[B0-1:0] = wrData[B0-1:0]; // [RULE2]
                        end
                    end
                    irq_ctrl_pkg::IDX_ENABLE1: begin
                        if (wrStrb) begin
                            srcEnable_d[NS-1:B0] = wrData[B1-1:0]; // [RULE2]
                        end
                    end
                    irq_ctrl_pkg::IDX_PRIO_LOW0: begin
                        if (wrStrb) begin
                            prioLow_d[B0-1:0] = wrData[B0-1:0]; // [RULE12]
                        end
                    end
                    irq_ctrl_pkg::IDX_PRIO_HIGH0: begin
                        if (wrStrb) begin
                            prioHigh_d[B0-1:0] = wrData[B0-1:0]; // [RULE12]
                        end
                    end
                    irq_ctrl_pkg::IDX_PRIO_LOW1: begin
                        if (wrStrb) begin
                            prioLow_d[NS-1:B0] = wrData[B1-1:0];
                        end
                    end
                    irq_ctrl_pkg::IDX_PRIO_HIGH1: begin
                        if (wrStrb) begin
                            prioHigh_d[NS-1:B0] = wrData[B1-1:0];
                        end
                    end
                    irq_ctrl_pkg::IDX_STATUS: begin
                        bresp_d = irq_ctrl_pkg::RESP_OKAY; // read-only, write ignored
                    end
                    default: begin
                        bresp_d = irq_ctrl_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            srcEnable_q <= '0;
            globalEn_q <= 1'b0;
            prioLow_q <= '0;
            prioHigh_q <= '0;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= irq_ctrl_pkg::REG_RESET;
            wStrb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= irq_ctrl_pkg::RESP_OKAY;
        end else begin
            srcEnable_q <= srcEnable_d;
            globalEn_q <= globalEn_d;
            prioLow_q <= prioLow_d;
            prioHigh_q <= prioHigh_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // ------------------------------------------------------------
    // arbitration and nesting
    // ------------------------------------------------------------
    logic [NS-1:0] rawReq, pending;
    logic winValid, eligible;
    logic [irq_ctrl_pkg::SRC_W-1:0] winSrc, grantSrc_q, grantSrc_d;
    logic [irq_ctrl_pkg::LEVEL_W-1:0] winLevel, topLevel, grantLevel_q, grantLevel_d;
    logic [irq_ctrl_pkg::NUM_LEVEL-1:0] inService_q, inService_d, topMask;
    logic irqReq_q, irqReq_d;
    logic [irq_ctrl_pkg::VEC_W-1:0] irqVector_q, irqVector_d;

    assign rawReq = {periphReq[NS-SW-1:1], extLevel_q[1], periphReq[0], extLevel_q[0]}; // [RULE1]
    // global gate sits after the per-source gate
    assign pending = rawReq & srcEnable_q & {NS{globalEn_q}}; // [RULE2] [RULE3]

    irq_arbiter i_irq_arbiter (
        .pending(pending),
        .prioLow(prioLow_q),
        .prioHigh(prioHigh_q),
        .winValid(winValid),
        .winSrc(winSrc),
        .winLevel(winLevel)
    );

    // highest level now in service
    always_comb begin
        topLevel = '0;
        topMask = '0;
        for (int l = 0; l < irq_ctrl_pkg::NUM_LEVEL; l++) begin
            if (inService_q[l]) begin
                topLevel = irq_ctrl_pkg::LEVEL_W'(l);
                topMask = '0;
                topMask[l] = 1'b1;
            end
        end
    end

    // nothing exceeds the top level, so it is never preempted
    assign eligible = winValid && (inService_q == '0 || winLevel > topLevel); // [RULE7] [RULE8]

    // grant is re-evaluated every cycle until the core accepts it
    always_comb begin
        irqReq_d = eligible && !(irqAck && irqReq_q); // [RULE14] quiet while the taken level lands
        grantSrc_d = winSrc;
        grantLevel_d = winLevel;
        case (winSrc)
            irq_ctrl_pkg::SRC_EXT0: irqVector_d = irq_ctrl_pkg::VEC_EXT0;
            irq_ctrl_pkg::SRC_TIMER0: irqVector_d = irq_ctrl_pkg::VEC_TIMER0;
            irq_ctrl_pkg::SRC_EXT1: irqVector_d = irq_ctrl_pkg::VEC_EXT1;
            irq_ctrl_pkg::SRC_TIMER1: irqVector_d = irq_ctrl_pkg::VEC_TIMER1;
            irq_ctrl_pkg::SRC_SERIAL: irqVector_d = irq_ctrl_pkg::VEC_SERIAL;
            irq_ctrl_pkg::SRC_TIMER2: irqVector_d = irq_ctrl_pkg::VEC_TIMER2;
            irq_ctrl_pkg::SRC_COUNTER: irqVector_d = irq_ctrl_pkg::VEC_COUNTER; // [RULE6]
            irq_ctrl_pkg::SRC_KEYPAD: irqVector_d = irq_ctrl_pkg::VEC_KEYPAD; // [RULE6]
            irq_ctrl_pkg::SRC_SPI: irqVector_d = irq_ctrl_pkg::VEC_SPI; // [RULE6]
            irq_ctrl_pkg::SRC_USB: irqVector_d = irq_ctrl_pkg::VEC_USB;
            irq_ctrl_pkg::SRC_AUX: irqVector_d = irq_ctrl_pkg::VEC_AUX;
            default: irqVector_d = irq_ctrl_pkg::VEC_EXT0;
        endcase
        inService_d = inService_q;
        // return pops the newest level before an accept in the same cycle
        if (irqReturn) begin
            inService_d = inService_q & ~topMask; // [RULE13] [RULE14]
        end
        if (irqAck && irqReq_q) begin
            inService_d[grantLevel_q] = 1'b1; // [RULE14]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqReq_q <= 1'b0;
            grantSrc_q <= '0;
            grantLevel_q <= '0;
            irqVector_q <= '0;
            inService_q <= '0;
        end else begin
            irqReq_q <= irqReq_d;
            grantSrc_q <= grantSrc_d;
            grantLevel_q <= grantLevel_d;
            irqVector_q <= irqVector_d;
            inService_q <= inService_d;
        end
    end

    assign irqReq = irqReq_q;
    assign irqVector = irqVector_q;
    assign irqLevel = grantLevel_q;
    // idle exits on any grant the core could take
    assign idleWake = irqReq_q;

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    logic rvalid_q, rvalid_d;
    logic [irq_ctrl_pkg::DATA_W-1:0] rdata_q, rdata_d, status;
    logic [1:0] rresp_q, rresp_d;
    logic [8:0] rdDec;

    assign arready = !rvalid_q;
    assign rdDec = decode(araddr);

    always_comb begin
        status = '0;
        status[irq_ctrl_pkg::ST_INSERV_LSB +: irq_ctrl_pkg::NUM_LEVEL] = inService_q;
        status[irq_ctrl_pkg::ST_SRC_LSB +: irq_ctrl_pkg::SRC_W] = grantSrc_q;
        status[irq_ctrl_pkg::ST_REQ_BIT] = irqReq_q;
        status[irq_ctrl_pkg::ST_LEVEL_LSB +: irq_ctrl_pkg::LEVEL_W] = grantLevel_q;
        status[irq_ctrl_pkg::ST_PEND_LSB +: NS] = rawReq;
        rvalid_d = rvalid_q && !rready;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rdata_d = '0;
            rresp_d = irq_ctrl_pkg::RESP_OKAY;
            if (!rdDec[8]) begin
                rresp_d = irq_ctrl_pkg::RESP_SLVERR;
            end else begin
                case (rdDec[7:0])
                    irq_ctrl_pkg::IDX_ENABLE0: rdata_d[B0:0] = {globalEn_q, srcEnable_q[B0-1:0]};
                    irq_ctrl_pkg::IDX_ENABLE1: rdata_d[B1-1:0] = srcEnable_q[NS-1:B0];
                    irq_ctrl_pkg::IDX_PRIO_LOW0: rdata_d[B0-1:0] = prioLow_q[B0-1:0];
                    irq_ctrl_pkg::IDX_PRIO_HIGH0: rdata_d[B0-1:0] = prioHigh_q[B0-1:0];
                    irq_ctrl_pkg::IDX_PRIO_LOW1: rdata_d[B1-1:0] = prioLow_q[NS-1:B0];
                    irq_ctrl_pkg::IDX_PRIO_HIGH1: rdata_d[B1-1:0] = prioHigh_q[NS-1:B0];
                    irq_ctrl_pkg::IDX_STATUS: rdata_d = status;
                    default: rresp_d = irq_ctrl_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= irq_ctrl_pkg::RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic betterLevel, betterPoll;

    // independent scan for a source that should have beaten the winner
    always_comb begin
        betterLevel = 1'b0;
        betterPoll = 1'b0;
        for (int i = 0; i < NS; i++) begin
            if (pending[i] && {prioHigh_q[i], prioLow_q[i]} > winLevel) begin
                betterLevel = 1'b1;
            end
            if (pending[i] && {prioHigh_q[i], prioLow_q[i]} == winLevel
                    && irq_ctrl_pkg::SRC_W'(i) < winSrc) begin
                betterPoll = 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_source_enable_gate: assert property ( // [RULE2]
        irqReq_q |-> $past(srcEnable_q[winSrc] && rawReq[winSrc]))
        else $error("grant for a disabled source");
    a_global_block: assert property (!globalEn_q |=> !irqReq_q) // [RULE3]
        else $error("grant while global enable clear");
    a_level_encode: assert property ( // [RULE5]
        irqReq_q |-> grantLevel_q == $past({prioHigh_q[winSrc], prioLow_q[winSrc]}))
        else $error("grant level does not match priority bits");
    a_vector_fixed: assert property ( // [RULE6]
        irqReq_q |-> (grantSrc_q != irq_ctrl_pkg::SRC_COUNTER || irqVector_q == 16'h0033)
            && (grantSrc_q != irq_ctrl_pkg::SRC_SPI || irqVector_q == 16'h004b)
            && (grantSrc_q != irq_ctrl_pkg::SRC_KEYPAD || irqVector_q == 16'h003b))
        else $error("wrong vector address");
    a_preempt_higher: assert property ( // [RULE7]
        irqReq_q |-> $past(inService_q) == 4'h0 || grantLevel_q > $past(topLevel))
        else $error("preemption by equal or lower level");
    a_top_level_hold: assert property (inService_q[3] |=> !irqReq_q) // [RULE8]
        else $error("top level service preempted");
    a_higher_level_wins: assert property (winValid |-> !betterLevel) // [RULE9]
        else $error("lower level chosen over higher");
    a_polling_order: assert property (winValid |-> !betterPoll) // [RULE10]
        else $error("polling order violated");
    a_global_bit_write: assert property ( // [RULE11]
        doWrite && wrDec == {1'b1, 8'ha8} && wrStrb |=> globalEn_q == $past(wrData[7]))
        else $error("global enable not taken from bit 7");
    a_prio_high_write: assert property ( // [RULE12]
        doWrite && wrDec == {1'b1, 8'hb7} && wrStrb |=> prioHigh_q[0] == $past(wrData[0]))
        else $error("high priority bits not at b7h");
    a_return_restores: assert property ( // [RULE13]
        irqReturn && !irqAck |=> inService_q == ($past(inService_q) & ~$past(topMask)))
        else $error("return did not restore previous level");

endmodule

`default_nettype wire

// ==== verif/irq_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // controller side
    input wire logic irqReq,
    output logic irqAck,
    output logic irqReturn
);
    int depth;
    int tmr;
    // takes a grant one cycle late; retires the newest service 30 cycles on
    // no ack twice in a row, so one grant is never taken twice
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {irqAck, irqReturn} <= 2'h0;
            depth = 0;
            tmr = 0;
        end else begin
            irqAck <= irqReq && !irqAck;
            irqReturn <= 1'b0;
            tmr = irqAck ? 0 : tmr + 1;
            depth = depth + ((irqAck && irqReq) ? 1 : 0);
            if (tmr == 30 && depth > 0) begin
                irqReturn <= 1'b1;
                depth = depth - 1;
                tmr = 0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/tb_four_level_vectored_interrupt_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_four_level_vectored_interrupt_controller;
    logic core_clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic irqReq, irqAck, irqReturn, idleWake, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [10:0] req = 0; // bits 10:9 drive the two request pins
    logic [15:0] irqVector;
    logic [1:0] irqLevel, bresp, rresp;
    logic [21:0] expQ[$]; // request bit, level, vector
    int fails = 0, comparisons = 0, seed = 32'h54ba6e42;
    irq_controller i_irq_controller (.core_clk, .arst_n, .extRequestPin(req[10:9]),
        .periphReq(req[8:0]), .irqReq, .irqVector, .irqLevel, .irqAck, .irqReturn, .idleWake,
        .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    irq_core_model i_irq_core_model (.core_clk, .arst_n, .irqReq, .irqAck, .irqReturn);
    initial forever #25 core_clk = ~core_clk;
    // usb and aux stay disabled, so their random noise must never be granted
    always @(posedge core_clk) req[8:7] <= 2'($random(seed));
    // each accepted grant is matched with the oldest note; its source then drops
    always @(posedge core_clk) if (irqAck && irqReq) begin
        if (expQ.size() == 0) chk(1, 0);
        else begin
            chk({irqLevel, irqVector}, expQ[0][17:0]);
            chk(idleWake, 1'b1);
            req[expQ[0][21:18]] <= 1'b0;
            void'(expQ.pop_front());
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do @(negedge core_clk); while (!(awready && wready));
        @(posedge core_clk);
        {awvalid, wvalid} <= 2'h0;
        do @(negedge core_clk); while (!bvalid);
        @(posedge core_clk);
        chk(bresp, irq_ctrl_pkg::RESP_OKAY);
    endtask
    task rd(input logic [7:0] idx, input logic bad, input logic [7:0] d);
        araddr <= {2'h0, idx, 2'h0};
        {arvalid, rready} <= 2'h3;
        do @(negedge core_clk); while (!arready);
        @(posedge core_clk);
        arvalid <= 1'b0;
        do @(negedge core_clk); while (!rvalid);
        @(posedge core_clk);
        chk(rresp, bad ? irq_ctrl_pkg::RESP_SLVERR : irq_ctrl_pkg::RESP_OKAY);
        if (!bad) chk(rdata, {24'h0, d});
    endtask
    // raise one source and note the grant it should earn
    task note(input logic [3:0] b, input logic [1:0] l, input logic [15:0] v);
        expQ.push_back({b, l, v});
        req[b] <= 1'b1;
    endtask
    // bounded wait for all noted grants, then let services retire
    task drain(input int tail);
        repeat (600) if (expQ.size() != 0) @(posedge core_clk);
        chk(expQ.size(), 0);
        repeat (tail) @(posedge core_clk);
    endtask
    task close_out;
        if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge core_clk);
        fails++;
        close_out;
    end
    // levels: counter 3, spi 2, serial 1, timer2 1, keypad 0
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rd(irq_ctrl_pkg::IDX_ENABLE0, 0, 8'h00);
        rd(8'h00, 1, 8'h00);
        wr(irq_ctrl_pkg::IDX_PRIO_LOW0, 8'h70);
        wr(irq_ctrl_pkg::IDX_PRIO_HIGH0, 8'h40);
        wr(irq_ctrl_pkg::IDX_PRIO_HIGH1, 8'h02);
        wr(irq_ctrl_pkg::IDX_ENABLE1, 8'h03);
        wr(irq_ctrl_pkg::IDX_ENABLE0, 8'h70);
        rd(irq_ctrl_pkg::IDX_PRIO_HIGH0, 0, 8'h40);
        note(4, 3, irq_ctrl_pkg::VEC_COUNTER);
        note(6, 2, irq_ctrl_pkg::VEC_SPI);
        note(2, 1, irq_ctrl_pkg::VEC_SERIAL);
        note(3, 1, irq_ctrl_pkg::VEC_TIMER2);
        note(5, 0, irq_ctrl_pkg::VEC_KEYPAD);
        repeat (5) @(posedge core_clk);
        chk(irqReq, 0);
        wr(irq_ctrl_pkg::IDX_ENABLE0, 8'hf4);
        repeat (20) if (expQ.size() == 5) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        chk(irqReq, 0);
        drain(100);
        note(5, 0, irq_ctrl_pkg::VEC_KEYPAD);
        drain(0);
        note(2, 1, irq_ctrl_pkg::VEC_SERIAL);
        drain(0);
        note(3, 1, irq_ctrl_pkg::VEC_TIMER2);
        repeat (4) @(posedge core_clk);
        chk(irqReq, 0);
        drain(100);
        note(10, 0, irq_ctrl_pkg::VEC_EXT1);
        drain(0);
        close_out;
    end
endmodule
`default_nettype wire
